// File: mcsr_pkg.sv
// Package: addresses, field positions, reset values and carriers of the core register set
package mcsr_pkg;

  // ==========================================================================
  // Register addresses in the upper special-register space
  // ==========================================================================
  localparam logic [7:0] SFR_BASE   = 8'h80;
  localparam logic [7:0] ADDR_SP    = 8'h81;
  localparam logic [7:0] ADDR_DPL   = 8'h82;
  localparam logic [7:0] ADDR_DPH   = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_CONTROL  = 8'h87;
  localparam logic [7:0] ADDR_CFG   = 8'haf;
  localparam logic [7:0] ADDR_SPH   = 8'hb7;
  localparam logic [7:0] ADDR_STACK_GUARD_CONTROL = 8'hbf;
  localparam logic [7:0] ADDR_PSW   = 8'hd0;
  localparam logic [7:0] ADDR_ACC   = 8'he0;
  localparam logic [7:0] ADDR_B     = 8'hf0;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PSW_CY    = 7;
  localparam int PSW_AC    = 6;
  localparam int PSW_F0    = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV    = 2;
  localparam int PSW_F1    = 1;
  localparam int PSW_P     = 0;
  localparam int PROGRAM_CONTROL_BAUD_DOUBLER = 7;
  localparam int SPH_KEEP  = 7;
  localparam int SPH_SBF   = 6;
  localparam int SPH_SSA_HI = 5;
  localparam int SPH_SSA_LO = 3;
  localparam int SPH_SP_HI = 2;
  localparam int SPH_SP_LO = 0;
  localparam int ST_WL_HI  = 7;
  localparam int ST_WL_LO  = 3;
  localparam int ST_ACT    = 2;
  localparam int ST_SBE    = 1;
  localparam int ST_WLF    = 0;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int STK_W     = 11;
  localparam int WL_PAD    = 6;
  localparam int SSA_PAD   = 8;
  localparam int BANK_PAD  = 3;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  RST_SPH   = 8'h89;
  localparam logic [7:0]  RST_CFG   = 8'h81;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [10:0] RST_STACK = 11'h100;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef enum logic [2:0] {
    ALU_NONE  = 3'b000,
    ALU_ADD   = 3'b001,
    ALU_ADDC  = 3'b010,
    ALU_SUBB  = 3'b011,
    ALU_MUL   = 3'b100,
    ALU_DIV   = 3'b101,
    ALU_LOGIC = 3'b110
  } mcsr_alu_op_t;

  typedef struct packed {
    mcsr_alu_op_t op;
    logic         cy;
    logic         ac;
    logic         ov;
  } mcsr_alu_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       direct;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcsr_sfr_req_t;

  typedef struct packed {
    logic       ack;
    logic       hit;
    logic [7:0] rdata;
  } mcsr_sfr_rsp_t;

  // Odd count of ones gives a set bit, so bit plus byte stays even
  function automatic logic mcsr_parity(input logic [7:0] v);
    return ^v;
  endfunction

endpackage

// File: mcsr_stack_ptr.sv
// Eleven-bit stack pointer with push, pop and byte writes
`timescale 1ns/1ps
module mcsr_stack_ptr (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      push,
  input  wire logic                      pop,
  input  wire logic                      lo_we,
  input  wire logic                      hi_we,
  input  wire logic [7:0]                wdata,
  output logic [mcsr_pkg::STK_W-1:0]     sp
);
  import mcsr_pkg::*;

  logic [STK_W-1:0] sp_r;
  logic [STK_W-1:0] sp_nxt;

  // Software writes win over a push or pop in the same cycle
  always_comb begin
    sp_nxt = sp_r;
    if (lo_we || hi_we) begin
      if (lo_we) sp_nxt[7:0] = wdata;
      if (hi_we) sp_nxt[STK_W-1:8] = wdata[SPH_SP_HI:SPH_SP_LO];
    end else if (push && !pop) begin
      sp_nxt = sp_r + 11'h001; // RULE_17
    end else if (pop && !push) begin
      sp_nxt = sp_r - 11'h001; // RULE_17
    end
  end

  // Low byte resets to zero, high bits to 001
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) sp_r <= RST_STACK; // RULE_10 RULE_11
    else       sp_r <= sp_nxt;
  end

  assign sp = sp_r;

  push_step_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
    (push && !pop && !lo_we && !hi_we) |=> sp_r == $past(sp_r) + 11'h001)
    else $error("push did not advance the stack pointer by one");
  pop_step_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
    (pop && !push && !lo_we && !hi_we) |=> sp_r == $past(sp_r) - 11'h001)
    else $error("pop did not lower the stack pointer by one");

endmodule // mcsr_stack_ptr

// File: mcsr_prog_ctr.sv
// Program counter and opcode holder, both outside the register space
`timescale 1ns/1ps
module mcsr_prog_ctr (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        advance,
  input  wire logic [1:0]  instr_len,
  input  wire logic        jump,
  input  wire logic [15:0] jump_addr,
  input  wire logic        opcode_load,
  input  wire logic [7:0]  opcode_in,
  output logic [15:0]      program_counter,
  output logic [7:0]       opcode_holder
);
  import mcsr_pkg::*;

  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  ir_r;

  // A jump overrides the step; lengths outside one to three are ignored
  assign pc_nxt = jump ? jump_addr :
                  (advance && instr_len != 2'b00) ? pc_r + {14'h0000, instr_len} : pc_r; // RULE_19

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) pc_r <= RST_WORD; // RULE_19
    else       pc_r <= pc_nxt;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)            ir_r <= RST_BYTE;
    else if (opcode_load) ir_r <= opcode_in;
  end

  assign program_counter = pc_r;
  assign opcode_holder   = ir_r;

  pc_step_a: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_19
    (advance && !jump && instr_len != 2'b00)
      |=> pc_r == $past(pc_r) + {14'h0000, $past(instr_len)})
    else $error("program counter did not advance by the instruction length");

endmodule // mcsr_prog_ctr

// File: mcsr_core_regs.sv
// Core special-register set: status word, math registers, pointers, stack guard
// Functional notes
// RULE_01 - Decode upper 128 bytes, direct addressing only
// RULE_02 - Program counter, opcode, banks stay outside space
// RULE_03 - Carry and overflow change only on arithmetic
// RULE_04 - Half carry changes only on add types
// RULE_05 - Two user flags hold whatever software writes
// RULE_06 - Bank select bits choose one of four banks
// RULE_07 - Parity bit keeps accumulator ones count even
// RULE_08 - Control bits stay low; bit seven doubles baud
// RULE_09 - Data pointer is high and low byte, reset zero
// RULE_10 - Stack low register holds eight low bits
// RULE_11 - Stack high bits two..zero, reset 001
// RULE_12 - Stack start address bits, reset 001
// RULE_13 - Software keeps stack high bit seven set
// RULE_14 - Violation gives interrupt or reset per action bit
// RULE_15 - Boundary check enable bit, reset disabled
// RULE_16 - Waterline setting and waterline flag, reset zero
// RULE_17 - Push increments then writes; pop reads then decrements
// RULE_18 - Four eight-register banks in lowest 32 bytes
// RULE_19 - Program counter resets zero, steps one to three
// RULE_20 - Climbing past waterline sets flag, counts violation
// RULE_21 - Falling below start address sets bottom flag
`timescale 1ns/1ps
module mcsr_core_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire mcsr_pkg::mcsr_sfr_req_t sfr_req,
  output mcsr_pkg::mcsr_sfr_rsp_t     sfr_rsp,
  input  wire mcsr_pkg::mcsr_alu_t    alu_flags,
  input  wire logic                   acc_we,
  input  wire logic [7:0]             acc_wdata,
  input  wire logic                   aux_we,
  input  wire logic [7:0]             aux_wdata,
  input  wire logic                   data_pointer_we,
  input  wire logic [15:0]            data_pointer_wdata,
  input  wire logic                   stack_push,
  input  wire logic                   stack_pop,
  input  wire logic                   pc_advance,
  input  wire logic [1:0]             pc_instr_len,
  input  wire logic                   pc_jump,
  input  wire logic [15:0]            pc_jump_addr,
  input  wire logic                   opcode_load,
  input  wire logic [7:0]             opcode_in,
  output logic [7:0]                  accumulator,
  output logic [7:0]                  aux_math,
  output logic [7:0]                  program_status_word,
  output logic [1:0]                  bank_select,
  output logic [4:0]                  bank_base_addr,
  output logic [15:0]                 data_pointer,
  output logic [mcsr_pkg::STK_W-1:0]  stack_addr,
  output logic                        baud_doubler,
  output logic [7:0]                  core_config,
  output logic [15:0]                 program_counter,
  output logic [7:0]                  opcode_holder,
  output logic                        stack_irq,
  output logic                        stack_reset_req
);
  import mcsr_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic [7:0]  acc_r, aux_r, psw_r, program_control_r, cfg_r, sph_r, stack_guard_control_r, dpl_r, dph_r;
  logic [7:0]  rdata_r;
  logic        ack_r, hit_r;
  logic        wl_cond_r, bt_cond_r, irq_r, rst_r;
  logic [STK_W-1:0] sp_w;

  // Indirect cycles and the lower half never reach the registers, so
  // program counter, opcode and bank storage cannot alias in here
  wire in_space = sfr_req.direct && (sfr_req.addr >= SFR_BASE); // RULE_01 RULE_02
  wire wr_ok    = sfr_req.wr && in_space;
  wire sel_sp   = sfr_req.addr == ADDR_SP;
  wire sel_dpl  = sfr_req.addr == ADDR_DPL;
  wire sel_dph  = sfr_req.addr == ADDR_DPH;
  wire sel_program_control = sfr_req.addr == ADDR_PROGRAM_CONTROL;
  wire sel_cfg  = sfr_req.addr == ADDR_CFG;
  wire sel_sph  = sfr_req.addr == ADDR_SPH;
  wire sel_st   = sfr_req.addr == ADDR_STACK_GUARD_CONTROL;
  wire sel_psw  = sfr_req.addr == ADDR_PSW;
  wire sel_acc  = sfr_req.addr == ADDR_ACC;
  wire sel_b    = sfr_req.addr == ADDR_B;
  wire mapped   = in_space && (sel_sp || sel_dpl || sel_dph || sel_program_control || sel_cfg ||
                  sel_sph || sel_st || sel_psw || sel_acc || sel_b);

  // Parity is never stored; it follows the accumulator combinationally
  wire parity_bit = mcsr_parity(acc_r); // RULE_07
  wire [7:0] psw_view = {psw_r[7:1], parity_bit};

  // Reserved control bits read as zero whatever was attempted
  wire [7:0] program_control_view = {program_control_r[PROGRAM_CONTROL_BAUD_DOUBLER], 7'h00}; // RULE_08

  wire [7:0] rd_mux = !mapped ? RST_BYTE :
                      sel_sp   ? sp_w[7:0] :
                      sel_dpl  ? dpl_r :
                      sel_dph  ? dph_r :
                      sel_program_control ? program_control_view :
                      sel_cfg  ? cfg_r :
                      sel_sph  ? {sph_r[7:3], sp_w[STK_W-1:8]} :
                      sel_st   ? stack_guard_control_r :
                      sel_psw  ? psw_view :
                      sel_acc  ? acc_r : aux_r;

  // One-cycle read answer from flops; unmapped reads answer zero, no hit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r   <= 1'b0;
      hit_r   <= 1'b0;
      rdata_r <= RST_BYTE;
    end else begin
      ack_r   <= sfr_req.rd || sfr_req.wr;
      hit_r   <= mapped;
      rdata_r <= sfr_req.rd ? rd_mux : RST_BYTE;
    end
  end
  assign sfr_rsp = '{ack: ack_r, hit: hit_r, rdata: rdata_r};

  // ==========================================================================
  // Accumulator and auxiliary math register
  // ==========================================================================
  // Datapath results take precedence over a register-space write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)                  acc_r <= RST_BYTE;
    else if (acc_we)            acc_r <= acc_wdata;
    else if (wr_ok && sel_acc)  acc_r <= sfr_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)                  aux_r <= RST_BYTE;
    else if (aux_we)            aux_r <= aux_wdata;
    else if (wr_ok && sel_b)    aux_r <= sfr_req.wdata;
  end

  // ==========================================================================
  // Program status word
  // ==========================================================================
  wire arith_op = alu_flags.op inside {ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV};
  wire add_op   = alu_flags.op inside {ALU_ADD, ALU_ADDC};
  logic [7:0] psw_nxt;

  // Software write first, then flags from the instruction just executed
  always_comb begin
    psw_nxt = psw_r;
    if (wr_ok && sel_psw) psw_nxt = sfr_req.wdata; // RULE_05 RULE_06
    if (arith_op) begin
      psw_nxt[PSW_CY] = alu_flags.cy; // RULE_03
      psw_nxt[PSW_OV] = alu_flags.ov; // RULE_03
    end
    if (add_op) psw_nxt[PSW_AC] = alu_flags.ac; // RULE_04
    psw_nxt[PSW_P] = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) psw_r <= RST_BYTE;
    else       psw_r <= psw_nxt;
  end

  assign bank_select    = psw_r[PSW_RS_HI:PSW_RS_LO]; // RULE_06
  assign bank_base_addr = {bank_select, {BANK_PAD{1'b0}}}; // RULE_18

  // ==========================================================================
  // Data pointer, program control, configuration
  // ==========================================================================
  // A whole-word load beats byte writes issued in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dpl_r <= RST_BYTE; // RULE_09
      dph_r <= RST_BYTE; // RULE_09
    end else if (data_pointer_we) begin
      dph_r <= data_pointer_wdata[15:8];
      dpl_r <= data_pointer_wdata[7:0];
    end else begin
      if (wr_ok && sel_dpl) dpl_r <= sfr_req.wdata;
      if (wr_ok && sel_dph) dph_r <= sfr_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      program_control_r <= RST_BYTE;
      cfg_r  <= RST_CFG;
    end else begin
      if (wr_ok && sel_program_control) program_control_r <= sfr_req.wdata;
      if (wr_ok && sel_cfg)  cfg_r  <= sfr_req.wdata;
    end
  end

  assign data_pointer = {dph_r, dpl_r}; // RULE_09
  assign baud_doubler = program_control_r[PROGRAM_CONTROL_BAUD_DOUBLER]; // RULE_08
  assign core_config  = cfg_r;

  // ==========================================================================
  // Stack pointer and boundary guard
  // ==========================================================================
  mcsr_stack_ptr u_stack (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .push    (stack_push),
    .pop     (stack_pop),
    .lo_we   (wr_ok && sel_sp),
    .hi_we   (wr_ok && sel_sph),
    .wdata   (sfr_req.wdata),
    .sp      (sp_w)
  );
  assign stack_addr = sp_w;

  wire [4:0] wl_level  = stack_guard_control_r[ST_WL_HI:ST_WL_LO];
  wire [2:0] start_hi  = sph_r[SPH_SSA_HI:SPH_SSA_LO];
  wire       chk_en    = stack_guard_control_r[ST_SBE]; // RULE_15
  wire       wl_cond   = chk_en && (sp_w > {wl_level, {WL_PAD{1'b0}}}); // RULE_20
  wire       bt_cond   = chk_en && (sp_w < {start_hi, {SSA_PAD{1'b0}}}); // RULE_21
  // Only the crossing counts, so a pointer parked past a limit fires once
  wire       wl_event  = wl_cond && !wl_cond_r;
  wire       bt_event  = bt_cond && !bt_cond_r;
  wire       violation = wl_event || bt_event;

  // Software may write both flags; a crossing in the same cycle wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sph_r   <= RST_SPH;  // RULE_11 RULE_12 RULE_13
      stack_guard_control_r <= RST_BYTE; // RULE_15 RULE_16
    end else begin
      if (wr_ok && sel_sph) sph_r <= sfr_req.wdata; // RULE_12
      if (wr_ok && sel_st)  stack_guard_control_r <= sfr_req.wdata; // RULE_16
      if (bt_event)         sph_r[SPH_SBF] <= 1'b1; // RULE_21
      if (wl_event)         stack_guard_control_r[ST_WLF] <= 1'b1; // RULE_20
    end
  end

  // Action bit steers the single violation pulse to one of two outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wl_cond_r <= 1'b0;
      bt_cond_r <= 1'b0;
      irq_r     <= 1'b0;
      rst_r     <= 1'b0;
    end else begin
      wl_cond_r <= wl_cond;
      bt_cond_r <= bt_cond;
      irq_r     <= violation && !stack_guard_control_r[ST_ACT]; // RULE_14
      rst_r     <= violation && stack_guard_control_r[ST_ACT]; // RULE_14
    end
  end
  assign stack_irq       = irq_r;
  assign stack_reset_req = rst_r;

  // ==========================================================================
  // Program counter and opcode holder
  // ==========================================================================
  mcsr_prog_ctr u_pc (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .advance         (pc_advance),
    .instr_len       (pc_instr_len),
    .jump            (pc_jump),
    .jump_addr       (pc_jump_addr),
    .opcode_load     (opcode_load),
    .opcode_in       (opcode_in),
    .program_counter (program_counter),
    .opcode_holder   (opcode_holder)
  );

  assign accumulator         = acc_r;
  assign aux_math            = aux_r;
  assign program_status_word = psw_view;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  indirect_miss_a: assert property (!sfr_req.direct && sfr_req.rd |=> !hit_r) // RULE_01
    else $error("indirect access reached the register space");
  bus_answer_a: assert property ((sfr_req.rd || sfr_req.wr) |=> sfr_rsp.ack) // RULE_01
    else $error("register access was not answered one cycle later");
  parity_even_a: assert property (^{acc_r, program_status_word[PSW_P]} == 1'b0) // RULE_07
    else $error("parity bit does not make the accumulator even");
  carry_hold_a: assert property (!arith_op && !(wr_ok && sel_psw) |=> $stable(psw_r[PSW_CY]) && $stable(psw_r[PSW_OV])) // RULE_03
    else $error("carry or overflow changed without arithmetic");
  carry_take_a: assert property (arith_op |=> psw_r[PSW_CY] == $past(alu_flags.cy)) // RULE_03
    else $error("carry not taken from arithmetic result");
  half_hold_a: assert property (!add_op && !(wr_ok && sel_psw) |=> $stable(psw_r[PSW_AC])) // RULE_04
    else $error("half carry changed outside add");
  user_flag_a: assert property (!(wr_ok && sel_psw) |=> $stable(psw_r[PSW_F0]) && $stable(psw_r[PSW_F1])) // RULE_05
    else $error("user flag changed without a write");
  bank_base_a: assert property (bank_base_addr == {psw_r[PSW_RS_HI:PSW_RS_LO], 3'b000}) // RULE_06 RULE_18
    else $error("bank base does not follow the select bits");
  data_pointer_load_a: assert property (data_pointer_we |=> data_pointer == $past(data_pointer_wdata)) // RULE_09
    else $error("data pointer word load lost");
  viol_route_a: assert property (violation |=> (stack_irq != stack_reset_req) && (stack_reset_req == $past(stack_guard_control_r[ST_ACT]))) // RULE_14
    else $error("stack violation routed to the wrong output");
  guard_off_a: assert property (!chk_en |=> !stack_irq && !stack_reset_req) // RULE_15
    else $error("violation raised while checking is disabled");
  wl_flag_a: assert property (wl_event |=> stack_guard_control_r[ST_WLF]) // RULE_20
    else $error("waterline crossing did not set its flag");
  bottom_flag_a: assert property (bt_event |=> sph_r[SPH_SBF]) // RULE_21
    else $error("bottom crossing did not set its flag");

endmodule // mcsr_core_regs

// File: mcsr_cpu_model.sv
// Instruction-side model that issues direct and indirect register accesses
`timescale 1ns/1ps
module mcsr_cpu_model (
  input  wire logic                    clk_sys,
  output mcsr_pkg::mcsr_sfr_req_t      sfr_req,
  input  wire mcsr_pkg::mcsr_sfr_rsp_t sfr_rsp
);
  import mcsr_pkg::*;

  // ==========
  // Bus idles with both strobes low
  initial sfr_req = '0;

  // One access: launch after an edge, held over the taking edge, answer read after it
  task automatic access(input logic wr, input logic dir, input logic [7:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata, output logic hit);
    logic [7:0] wd;
    wd = wdata;
    if (wr && addr == ADDR_PROGRAM_CONTROL) wd[6:0] = 7'h00;
    if (wr && addr == ADDR_SPH) wd[SPH_KEEP] = 1'b1;
    @(posedge clk_sys);
    #1 sfr_req = '{rd: !wr, wr: wr, direct: dir, addr: addr, wdata: wd};
    @(posedge clk_sys);
    #1 rdata = sfr_rsp.rdata;
    hit = sfr_rsp.hit;
    sfr_req = '0;
  endtask
endmodule // mcsr_cpu_model

// File: mcsr_core_regs_tb.sv
// Self-checking bench for the core register set
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module mcsr_core_regs_tb;
  import mcsr_pkg::*;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       dir;
    logic [7:0] exp;
    logic       hit;
  } mcsr_row_t;

  // ==========
  logic clk_sys, rstn, acc_we, aux_we, data_pointer_we, stack_push, stack_pop;
  logic pc_advance, pc_jump, opcode_load, baud_doubler, stack_irq, stack_reset_req, hit_v;
  logic [7:0]  acc_wdata, aux_wdata, opcode_in, accumulator, aux_math, core_config, rd_v;
  logic [7:0]  program_status_word, opcode_holder;
  logic [15:0] data_pointer_wdata, pc_jump_addr, data_pointer, program_counter;
  logic [1:0]  pc_instr_len, bank_select;
  logic [4:0]  bank_base_addr;
  logic [10:0] stack_addr;
  mcsr_sfr_req_t sfr_req;
  mcsr_sfr_rsp_t sfr_rsp;
  mcsr_alu_t     alu_flags;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] pv [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hfe, 8'hff};
  // Write then read back; indirect and low or unmapped places must miss
  mcsr_row_t rows [11] = '{
    '{8'h81, 8'ha5, 1'b1, 8'ha5, 1'b1}, '{8'h82, 8'h34, 1'b1, 8'h34, 1'b1},
    '{8'h83, 8'h12, 1'b1, 8'h12, 1'b1}, '{8'h87, 8'hff, 1'b1, 8'h80, 1'b1},
    '{8'haf, 8'h5a, 1'b1, 8'h5a, 1'b1}, '{8'he0, 8'h07, 1'b1, 8'h07, 1'b1},
    '{8'hf0, 8'h3c, 1'b1, 8'h3c, 1'b1}, '{8'hd0, 8'h18, 1'b1, 8'h19, 1'b1},
    '{8'h90, 8'h55, 1'b1, 8'h00, 1'b0}, '{8'h7f, 8'h11, 1'b1, 8'h00, 1'b0},
    '{8'he0, 8'hff, 1'b0, 8'h00, 1'b0}};

  mcsr_core_regs u_mcsr_core_regs (.clk_sys, .rstn, .sfr_req, .sfr_rsp, .alu_flags, .acc_we,
    .acc_wdata, .aux_we, .aux_wdata, .data_pointer_we, .data_pointer_wdata, .stack_push, .stack_pop,
    .pc_advance, .pc_instr_len, .pc_jump, .pc_jump_addr, .opcode_load, .opcode_in,
    .accumulator, .aux_math, .program_status_word, .bank_select, .bank_base_addr,
    .data_pointer, .stack_addr, .baud_doubler, .core_config, .program_counter,
    .opcode_holder, .stack_irq, .stack_reset_req);
  mcsr_cpu_model u_mcsr_cpu_model (.clk_sys, .sfr_req, .sfr_rsp);

  // ==========
  // Free-running core clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cut a hang short; the full sequence needs under two hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ==========
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_sys);
    #1 s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    u_mcsr_cpu_model.access(1'b1, 1'b1, a, d, rd_v, hit_v);
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    u_mcsr_cpu_model.access(1'b0, 1'b1, a, 8'h00, rd_v, hit_v);
  endtask
  // Violation must give exactly one pulse of the selected kind
  task automatic expect_viol(input logic want_rst);
    int n;
    n = 0;
    while (!(stack_irq || stack_reset_req) && n < 6) begin
      tick();
      n++;
    end
    `CHK("irq", !want_rst, stack_irq)
    `CHK("reset req", want_rst, stack_reset_req)
    tick();
    `CHK("pulse end", 2'b00, {stack_irq, stack_reset_req})
  endtask
  // Reset held two cycles; values checked while held, then through the bus
  task automatic rst_seq();
    rstn = 1'b0;
    repeat (2) tick();
    `CHK("psw", 8'h00, program_status_word)
    `CHK("stack", 11'h100, stack_addr)
    `CHK("data_pointer", 16'h0000, data_pointer)
    `CHK("pc", 16'h0000, program_counter)
    `CHK("baud", 1'b0, baud_doubler)
    `CHK("cfg", 8'h81, core_config)
    rstn = 1'b1;
    sfr_rd(ADDR_SPH);
    `CHK("sph", 8'h89, rd_v)
    sfr_rd(ADDR_STACK_GUARD_CONTROL);
    `CHK("stack_guard_control", 8'h00, rd_v)
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========
  // Main sequence: reset checks first, then table, then hand-written cases
  initial begin
    {acc_we, aux_we, data_pointer_we, stack_push, stack_pop, pc_advance, pc_jump, opcode_load} = '0;
    {acc_wdata, aux_wdata, opcode_in, data_pointer_wdata, pc_jump_addr, pc_instr_len} = '0;
    alu_flags = '0;
    rst_seq();
    foreach (rows[i]) begin
      u_mcsr_cpu_model.access(1'b1, rows[i].dir, rows[i].addr, rows[i].wdata, rd_v, hit_v);
      u_mcsr_cpu_model.access(1'b0, rows[i].dir, rows[i].addr, 8'h00, rd_v, hit_v);
      `CHK("read", rows[i].exp, rd_v)
      `CHK("hit", rows[i].hit, hit_v)
    end
    `CHK("acc kept", 8'h07, accumulator)
    `CHK("data_pointer", 16'h1234, data_pointer)
    `CHK("stack", 11'h1a5, stack_addr)
    `CHK("baud", 1'b1, baud_doubler)
    for (int b = 0; b < 4; b++) begin
      sfr_wr(ADDR_PSW, 8'(b << 3));
      `CHK("bank", 2'(b), bank_select)
      `CHK("bank base", 5'(b << 3), bank_base_addr)
    end
    foreach (pv[i]) begin
      acc_wdata = pv[i];
      pulse(acc_we);
      `CHK("parity", ^pv[i], program_status_word[PSW_P])
    end
    // Flags set high on every op; only arithmetic may move them
    for (int op = 0; op < 7; op++) begin
      sfr_wr(ADDR_PSW, 8'h22);
      @(posedge clk_sys);
      #1 alu_flags = '{op: mcsr_alu_op_t'(op), cy: 1'b1, ac: 1'b1, ov: 1'b1};
      tick();
      alu_flags = '0;
      `CHK("flags", {op inside {[1:5]}, op inside {[1:2]}, 3'b100, op inside {[1:5]}, 1'b1},
           program_status_word[7:1])
    end
    // Push across the low-byte boundary, then pop back
    sfr_wr(ADDR_SP, 8'hff);
    pulse(stack_push);
    `CHK("push", 11'h200, stack_addr)
    sfr_rd(ADDR_SPH);
    `CHK("sph", 8'h8a, rd_v)
    pulse(stack_pop);
    `CHK("pop", 11'h1ff, stack_addr)
    sfr_wr(ADDR_STACK_GUARD_CONTROL, 8'h0a);
    expect_viol(1'b0);
    sfr_rd(ADDR_STACK_GUARD_CONTROL);
    `CHK("waterline flag", 8'h0b, rd_v)
    sfr_wr(ADDR_STACK_GUARD_CONTROL, 8'h00);
    sfr_wr(ADDR_STACK_GUARD_CONTROL, 8'h0e);
    expect_viol(1'b1);
    sfr_wr(ADDR_STACK_GUARD_CONTROL, 8'hf8);
    sfr_wr(ADDR_SPH, 8'h91);
    sfr_rd(ADDR_SPH);
    `CHK("no flag off", 8'h91, rd_v)
    sfr_wr(ADDR_STACK_GUARD_CONTROL, 8'hfa);
    expect_viol(1'b0);
    sfr_rd(ADDR_SPH);
    `CHK("bottom flag", 8'hd1, rd_v)
    pc_instr_len = 2'd3;
    pulse(pc_advance);
    `CHK("pc", 16'h0003, program_counter)
    pc_jump_addr = 16'h1234;
    pulse(pc_jump);
    `CHK("pc jump", 16'h1234, program_counter)
    opcode_in = 8'ha7;
    pulse(opcode_load);
    `CHK("opcode", 8'ha7, opcode_holder)
    data_pointer_wdata = 16'hbeef;
    pulse(data_pointer_we);
    sfr_rd(ADDR_DPH);
    `CHK("data_pointer high", 8'hbe, rd_v)
    aux_wdata = 8'h99;
    pulse(aux_we);
    `CHK("aux", 8'h99, aux_math)
    rst_seq();
    wrap_up();
  end
endmodule // mcsr_core_regs_tb
